// >>> verilog/pmo_cfg.svh
// Purpose: Timing and reset constants for the PDM microphone output port
// Assumes: System clock of 200 MHz (5 ns period)
// Notes:   Cycle counts follow from the rates and times below and the clock period
`ifndef PMO_CFG_SVH
`define PMO_CFG_SVH

`define PMO_CLK_PERIOD_NS   5
// Sleep is entered when the bit clock falls below this rate
`define PMO_SLEEP_FREQ_KHZ  200
// Longest bit-clock period still awake, rounded down to whole cycles
`define PMO_SLEEP_CYC       (1000000 / (`PMO_SLEEP_FREQ_KHZ * `PMO_CLK_PERIOD_NS))
// Bit-clock rate that selects low-power listening
`define PMO_LPL_FREQ_KHZ    768
`define PMO_LPL_CYC         (1000000 / (`PMO_LPL_FREQ_KHZ * `PMO_CLK_PERIOD_NS))
// Accepted deviation of the measured period around the listening rate
`define PMO_LPL_TOL_CYC     8
// Wake-up and start-up settling time
`define PMO_WAKE_MS         6
`define PMO_WAKE_CYC        (`PMO_WAKE_MS * 1000000 / `PMO_CLK_PERIOD_NS)
// Reset values
`define PMO_RST_DATA        1'b0
`define PMO_RST_OE          1'b0

`endif

// >>> verilog/pmo_pkg.sv
// Purpose: Types shared by the PDM microphone output port
// Assumes: Nothing beyond SystemVerilog 2012
// Notes:   Operating modes are chosen from the measured bit-clock rate
package pmo_pkg;

    // Operating mode of the microphone
    typedef enum logic [1:0]
    {
        pmo_mode_sleep,
        pmo_mode_normal,
        pmo_mode_low_power_listen
    } pmo_mode_t;

endpackage : pmo_pkg

// >>> verilog/pmo_pdm_port.sv
// Purpose: PDM data output port of a digital microphone, with modulator and FIFO
// Assumes: Bit clock and select pin are synchronous to i_clk; i_clk is 200 MHz
// Notes:   Data pin is tristate: o_pdm_data is the value, o_pdm_oe high while driving
`include "pmo_cfg.svh"

// Sample FIFO between the audio source and the modulator
module pmo_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    import pmo_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [CW-1:0]           count;
        logic                    not_full;
        logic                    not_empty;
    } pmo_fifo_st_t;

    pmo_fifo_st_t st;
    pmo_fifo_st_t next_st;
    logic         push;
    logic         pop;

    // Handshakes on both sides
    assign push        = i_in_valid && st.not_full;
    assign pop         = i_out_ready && st.not_empty;
    assign o_in_ready  = st.not_full;
    assign o_out_valid = st.not_empty;
    assign o_out_data  = st.mem[st.rptr];

    // Pointer and flag update; flags are registered so ready comes from a flop
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wptr] = i_in_data;
            next_st.wptr         = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop)
        begin
            next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
        end
        next_st.count     = st.count + CW'(push) - CW'(pop);
        next_st.not_full  = (next_st.count != CW'(DEPTH));
        next_st.not_empty = (next_st.count != '0);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st          <= '0;
            st.not_full <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_fifo_no_overflow: assert property (st.count <= CW'(DEPTH))
        else $error("FIFO count beyond depth");

endmodule // pmo_fifo

module pmo_pdm_port #(
    parameter int W         = 16,
    parameter int DEPTH     = 16,
    parameter int WAKE_CYC  = `PMO_WAKE_CYC,
    parameter int SLEEP_CYC = `PMO_SLEEP_CYC
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_pdm_clk,
    input  wire logic          i_select,
    input  wire logic          i_sample_valid,
    input  wire logic [W-1:0]  i_sample,
    output logic               o_sample_ready,
    output logic               o_pdm_data,
    output logic               o_pdm_oe,
    output pmo_pkg::pmo_mode_t o_mode,
    output logic               o_settled
);
    import pmo_pkg::*;

    localparam int CW  = $clog2(SLEEP_CYC + 1);
    localparam int WW  = $clog2(WAKE_CYC + 1);
    localparam int AWD = W + 2;
    localparam logic signed [AWD-1:0] FS     = AWD'((2 ** (W - 1)) - 1);
    localparam logic [CW-1:0]         LPL_LO = CW'(`PMO_LPL_CYC - `PMO_LPL_TOL_CYC);
    localparam logic [CW-1:0]         LPL_HI = CW'(`PMO_LPL_CYC + `PMO_LPL_TOL_CYC);

    typedef struct packed {
        logic                  clk_prev;
        logic                  sel_done;
        logic                  left;
        logic [CW-1:0]         cnt;
        pmo_mode_t             mode;
        logic [WW-1:0]         wake;
        logic                  settled;
        logic signed [AWD-1:0] acc;
        logic [W-1:0]          hold;
        logic                  data;
        logic                  oe;
    } pmo_st_t;

    pmo_st_t          st;
    pmo_st_t          next_st;
    logic             rise;
    logic             fall;
    logic             launch;
    logic             release_edge;
    logic             fifo_valid;
    logic [W-1:0]     fifo_data;
    logic             fifo_ready;
    logic             fifo_pop;
    logic [CW-1:0]    period;

    // Bit-clock edges; the pin is already synchronous so one register suffices
    assign rise         = i_pdm_clk && !st.clk_prev;
    assign fall         = !i_pdm_clk && st.clk_prev;
    assign launch       = st.sel_done && (st.left ? fall : rise);
    assign release_edge = st.sel_done && (st.left ? rise : fall);
    assign fifo_pop     = launch && (st.mode != pmo_mode_sleep);
    assign period       = st.cnt + 1'b1;
    assign o_sample_ready = fifo_ready;

    // Source samples wait here; one is drawn per launched bit
    pmo_fifo #(
        .W     (W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_sample_valid),
        .i_in_data   (i_sample),
        .o_in_ready  (fifo_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop)
    );

    // Port, mode and modulator state update
    always_comb
    begin
        logic [W-1:0]          x;
        logic signed [AWD-1:0] xe;
        logic                  bit_out;
        x       = '0;
        xe      = '0;
        bit_out = 1'b0;
        next_st = st;
        next_st.clk_prev = i_pdm_clk;

        // Channel select taken once, on the first cycle after reset
        if (!st.sel_done)
        begin
            next_st.sel_done = 1'b1;
            next_st.left     = i_select;
        end

        // Measure the bit-clock period; saturates once sleep is certain
        if (rise)
        begin
            next_st.cnt = '0;
        end
        else if (st.cnt != CW'(SLEEP_CYC))
        begin
            next_st.cnt = st.cnt + 1'b1;
        end

        // Mode from the measured rate, no software involvement
        if (rise)
        begin
            if (st.cnt >= CW'(SLEEP_CYC))
            begin
                next_st.mode = pmo_mode_sleep;
            end
            else if (period >= LPL_LO && period <= LPL_HI)
            begin
                next_st.mode = pmo_mode_low_power_listen;
            end
            else
            begin
                next_st.mode = pmo_mode_normal;
            end
        end
        else if (st.cnt == CW'(SLEEP_CYC))
        begin
            next_st.mode = pmo_mode_sleep;
        end

        // Settling timer restarts whenever the clock is lost, including at power-up
        if (next_st.mode == pmo_mode_sleep)
        begin
            next_st.wake    = '0;
            next_st.settled = 1'b0;
        end
        else if (st.wake == WW'(WAKE_CYC))
        begin
            next_st.settled = 1'b1;
        end
        else
        begin
            next_st.wake = st.wake + 1'b1;
        end

        // Modulator steps once per period at the launch edge
        case (st.mode)
            pmo_mode_sleep:
            begin
                next_st.oe = 1'b0;
            end
            pmo_mode_normal,
            pmo_mode_low_power_listen:
            begin
                if (launch)
                begin
                    x = fifo_valid ? fifo_data : st.hold;
                    // Most negative code folded in so both rails are symmetric
                    if (x == {1'b1, {(W-1){1'b0}}})
                    begin
                        x = x + 1'b1;
                    end
                    xe              = {{2{x[W-1]}}, x};
                    bit_out         = !st.acc[AWD-1];
                    next_st.acc     = st.acc + xe - (bit_out ? FS : -FS);
                    next_st.hold    = x;
                    next_st.data    = bit_out;
                    next_st.oe      = 1'b1;
                end
                else if (release_edge)
                begin
                    next_st.oe = 1'b0;
                end
            end
            default:
            begin
                next_st.oe = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st      <= '0;
            st.mode <= pmo_mode_sleep;
            st.cnt  <= CW'(SLEEP_CYC);  // Power-up counts as sleep, so no bogus period is classified
            st.data <= `PMO_RST_DATA;
            st.oe   <= `PMO_RST_OE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign o_pdm_data = st.data;
    assign o_pdm_oe   = st.oe;
    assign o_mode     = st.mode;
    assign o_settled  = st.settled;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_sleep_released: assert property ((st.mode == pmo_mode_sleep) |=> !o_pdm_oe)
        else $error("Data driven while asleep");
    a_right_launch: assert property (st.sel_done && !st.left && rise && st.mode != pmo_mode_sleep
                                     |=> o_pdm_oe)
        else $error("Right slot not driven after rising edge");
    a_left_launch: assert property (st.sel_done && st.left && fall && st.mode != pmo_mode_sleep
                                    |=> o_pdm_oe)
        else $error("Left slot not driven after falling edge");
    a_half_release: assert property (release_edge |=> !o_pdm_oe)
        else $error("Data line not released for other half");
    a_oe_on_launch: assert property ($rose(o_pdm_oe) |-> $past(launch))
        else $error("Drive started outside the launch edge");
    a_select_frozen: assert property (st.sel_done |=> $stable(st.left) && st.sel_done)
        else $error("Channel select changed after capture");
    a_sleep_entry: assert property (st.cnt == CW'(SLEEP_CYC) && !rise
                                    |=> o_mode == pmo_mode_sleep)
        else $error("Slow clock did not enter sleep");
    a_listen_entry: assert property (rise && st.cnt < CW'(SLEEP_CYC) && period >= LPL_LO && period <= LPL_HI
                                     |=> o_mode == pmo_mode_low_power_listen)
        else $error("Listening rate not detected");
    a_wake_unsettled: assert property ((st.mode == pmo_mode_sleep) |=> !o_settled)
        else $error("Settled flag up while asleep");
    a_acc_bounded: assert property (st.acc <= 2 * FS && st.acc >= -2 * FS)
        else $error("Modulator integrator beyond bound");
    a_zero_toggles: assert property (launch && st.mode != pmo_mode_sleep && st.acc == '0
                                     && fifo_valid && fifo_data == '0
                                     |=> o_pdm_data && st.acc == -FS)
        else $error("Zero input did not alternate");

endmodule // pmo_pdm_port

// >>> tb/pmo_codec_model.sv
// Purpose: Codec stand-in that makes the bit clock and decodes one slot
// Assumes: Bit clock is derived from i_clk, so both are synchronous
// Notes:   Reports ones and bit changes per window of 16 decoded bits
module pmo_codec_model (
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic        i_left,
    input  wire logic [9:0]  i_half,
    input  wire logic        i_data,
    input  wire logic        i_oe,
    output logic             o_pdm_clk,
    output logic             o_win,
    output logic [19:0]      o_ones,
    output logic [4:0]       o_edges
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0]  cnt = '0;
    logic [4:0]  nbits = '0;
    logic [19:0] acc_ones;  // Wide enough for a real decimator
    logic [4:0]  acc_edges;
    logic        prev_bit;
    logic        last = 1'b0;
    logic        wire_lvl;

    // No pull on the line: once released it flips to the inverse of its last level on every i_clk cycle
    assign wire_lvl = i_oe ? i_data : ~last;

    initial
    begin
        o_pdm_clk = 1'b0;
        o_win     = 1'b0;
        o_ones    = '0;
        o_edges   = '0;
    end

    // Clock runs only on request and parks low, so it stands still between frames
    always @(negedge i_clk)
    begin
        o_win <= 1'b0;
        last  <= wire_lvl;
        if (!i_run && !o_pdm_clk)
            cnt <= '0;
        else if (cnt + 10'd1 >= i_half)
        begin
            cnt       <= '0;
            o_pdm_clk <= ~o_pdm_clk;
            // A slot closes at the edge after its launch; only our slot is decoded
            if (o_pdm_clk != i_left)
            begin
                // Counts restart every window, so a steady offset never builds up
                acc_ones  <= ((nbits == 5'd0) ? 20'd0 : acc_ones) + 20'(wire_lvl);
                acc_edges <= ((nbits == 5'd0) ? 5'd0 : acc_edges) + 5'(nbits != 5'd0 && wire_lvl != prev_bit);
                prev_bit  <= wire_lvl;
                nbits     <= (nbits == 5'd15) ? 5'd0 : nbits + 5'd1;
                if (nbits == 5'd15)
                begin
                    o_win   <= 1'b1;
                    o_ones  <= acc_ones + 20'(wire_lvl);
                    o_edges <= acc_edges + 5'(wire_lvl != prev_bit);
                end
            end
        end
        else
            cnt <= cnt + 10'd1;
    end
endmodule // pmo_codec_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the PDM microphone output port
// Assumes: Codec model makes the bit clock from i_clk
// Notes:   Decoded windows are judged against notes queued by the driver
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pmo_pkg::*;
    typedef struct {int lo; int hi; int elo; int ehi;} pmo_note_t;
    localparam int WAKE = 50;
    logic        clk, rst, sel, run, left, valid, ready, data, oe, settled, pclk, win, plast;
    logic [15:0] smp;
    logic [9:0]  half;
    logic [19:0] ones;
    logic [4:0]  edges;
    pmo_mode_t   mode, pmode;
    pmo_note_t   q[$];
    pmo_note_t   nt;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, stab = 0, mstab = 0, i, x, e;

    pmo_pdm_port #(.WAKE_CYC(WAKE), .SLEEP_CYC(1000)) uut (
        .i_clk(clk), .i_rst(rst), .i_pdm_clk(pclk), .i_select(sel), .i_sample_valid(valid),
        .i_sample(smp), .o_sample_ready(ready), .o_pdm_data(data), .o_pdm_oe(oe),
        .o_mode(mode), .o_settled(settled));
    pmo_codec_model far (
        .i_clk(clk), .i_run(run), .i_left(left), .i_half(half), .i_data(data), .i_oe(oe),
        .o_pdm_clk(pclk), .o_win(win), .o_ones(ones), .o_edges(edges));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard, well above the roughly 24k cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            test_done();
        end
    end

    // Pin ownership per half period, and judging of each decoded window
    always @(posedge clk)
    begin
        stab  = (rst || pclk !== plast) ? 0 : stab + 1;
        mstab = (rst || mode !== pmode) ? 0 : mstab + 1;
        plast = pclk;
        pmode = mode;
        if (stab > 2 && mstab > 4 * half + 4)
            chk("data_enable", oe, mode !== pmo_mode_sleep && pclk === !left);
        if (win === 1'b1 && q.size() > 0)
        begin
            nt = q.pop_front();
            chk("ones_band", ones >= nt.lo && ones <= nt.hi, 1);
            chk("bit_changes", edges >= nt.elo && edges <= nt.ehi, 1);
        end
    end

    // Offer one word at a falling edge and hold it until an edge takes it
    task automatic put(input logic [15:0] s);
        int n;
        smp   = s;
        valid = 1'b1;
        for (n = 0; n < 100 && ready !== 1'b1; n++)
            @(negedge clk);
        if (n == 100)
            error_cnt++;
        @(negedge clk);
    endtask

    // Two windows are skipped while the modulator settles on the new level
    task automatic expect_win(input int lo, input int hi, input int elo, input int ehi);
        int n;
        q.push_back('{0, 16, 0, 15});
        q.push_back('{0, 16, 0, 15});
        q.push_back('{lo, hi, elo, ehi});
        for (n = 0; n < 20000 && q.size() > 0; n++)
            @(negedge clk);
        chk("window_seen", q.size(), 0);
    endtask

    // Start the bit clock and time the settling flag from leaving sleep
    task automatic wake(input logic [9:0] h);
        int n;
        half = h;
        run  = 1'b1;
        for (n = 0; n < 3000 && mode === pmo_mode_sleep; n++)
            @(negedge clk);
        for (n = 0; n < 200 && settled !== 1'b1; n++)
            @(negedge clk);
        chk("settle_cycles", n, WAKE);
    endtask

    initial
    begin
        rst   = 1'b1;
        sel   = 1'b0;
        run   = 1'b0;
        left  = 1'b0;
        valid = 1'b0;
        smp   = '0;
        half  = 10'd10;
        void'($urandom(32'h86cd));
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("mode", mode, pmo_mode_sleep);
        chk("settled", settled, 0);
        chk("oe", oe, 0);
        // Clock parked, so nothing drains: fill the buffer until it refuses
        for (i = 0; i < 16; i++)
            put(16'h8000);
        valid = 1'b0;
        @(negedge clk);
        chk("ready_full", ready, 0);
        smp   = 16'h7fff;
        valid = 1'b1;
        repeat (4) @(negedge clk);
        chk("ready_refused", ready, 0);
        valid = 1'b0;
        sel   = 1'b1;
        wake(10'd10);
        chk("mode", mode, pmo_mode_normal);
        expect_win(0, 0, 0, 0);
        $display("test fill_refuse_wake done");
        // Full scale, zero, then random levels
        for (i = 0; i < 5; i++)
        begin
            x = (i == 0) ? 32767 : (i == 1) ? 0 : int'($urandom_range(32000)) - 16000;
            put(16'(x));
            valid = 1'b0;
            e = ((x + 32767) * 16 + 32767) / 65534;
            expect_win(i < 2 ? e : e - 1, i < 2 ? e : e + 1, i == 1 ? 15 : 0, i == 0 ? 0 : 15);
        end
        $display("test density done");
        half = 10'd130;
        for (i = 0; i < 2000 && mode !== pmo_mode_low_power_listen; i++)
            @(negedge clk);
        chk("mode", mode, pmo_mode_low_power_listen);
        // Back to a zero level so the listening-mode stream must alternate
        put(16'h0000);
        valid = 1'b0;
        expect_win(8, 8, 15, 15);
        half = 10'd495;
        repeat (3000) @(negedge clk);
        chk("mode", mode, pmo_mode_normal);
        $display("test clock_modes done");
        run = 1'b0;
        repeat (1400) @(negedge clk);
        chk("mode", mode, pmo_mode_sleep);
        chk("oe", oe, 0);
        chk("settled", settled, 0);
        wake(10'd10);
        $display("test sleep_wake done");
        // Second reset with select high: the left slot from then on
        run = 1'b0;
        repeat (40) @(negedge clk);
        rst  = 1'b1;
        sel  = 1'b1;
        left = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        sel = 1'b0;
        wake(10'd10);
        put(16'h0000);
        valid = 1'b0;
        expect_win(8, 8, 15, 15);
        $display("test left_slot done");
        test_done();
    end
endmodule // tb_top
